// ==== common/byte_bit_op_regs.vh ====
// Purpose: Constants for the byte and bit operation executor
// Assumes: Wishbone classic slave, 32-bit data, word aligned offsets
// Notes:   Opcode field codes are local encodings for this block
`ifndef BYTE_BIT_OP_REGS_VH
`define BYTE_BIT_OP_REGS_VH

// Register byte offsets
`define OFF_INSTR        8'h00
`define OFF_ACC          8'h04
`define OFF_FLAGS        8'h08
`define OFF_RESULT       8'h0c
`define OFF_FILE_ADDR    8'h10
`define OFF_FILE_DATA    8'h14

// Instruction word fields
`define INSTR_OP_LSB     16
`define INSTR_OP_MSB     18
`define INSTR_DEST_BIT   15
`define INSTR_BIT_LSB    8
`define INSTR_BIT_MSB    10
`define INSTR_OPND_LSB   0
`define INSTR_OPND_MSB   7

// Operation codes
`define OP_ADD_IMM       3'h0
`define OP_AND_IMM       3'h1
`define OP_ADD_FILE      3'h2
`define OP_AND_FILE      3'h3
`define OP_BIT_CLEAR     3'h4
`define OP_BIT_SET       3'h5
`define OP_TEST_SKIP     3'h6
`define OP_ZERO_FILE     3'h7

// Flag register bit positions
`define FLAG_CARRY       0
`define FLAG_NIBBLE      1
`define FLAG_ZERO        2
`define FLAG_SKIP        3
`define FLAG_BUSY        4

// Reset values
`define ACC_RESET        8'h00
`define FLAGS_RESET      3'h0

// Timing: instruction period in clock cycles, skipped test takes two periods
`define PERIOD_CYCLES    1
`define SKIP_PERIODS     2

`endif

// ==== rtl/byte_bit_op_executor.v ====
// Purpose: Executes add, AND, bit clear/set, bit test skip and file clear
// Assumes: Software issues instructions over classic Wishbone, one per write
// Notes:   File registers are a local 128 byte array reachable from the bus
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "byte_bit_op_regs.vh"

// Contract
// - Add immediate into accumulator, set carry, nibble, zero
// - AND immediate into accumulator, update only Z
// - Add accumulator and file, set carry, nibble, zero
// - AND accumulator with file, update only Z
// - Destination zero is accumulator, one is file
// - Bit clear in file, flags unchanged
// - Bit set in file, flags unchanged
// - Tested bit one skips next, two periods
// - Tested bit zero runs next, flags unchanged
// - Clear file loads zero into file
// - Clear file always sets zero flag
// - True test takes second idle cycle
module byte_bit_op_executor
#(
    parameter FILE_DEPTH = 128,
    parameter ADDR_WIDTH = 7
)
(
    // Clock and reset
    input  wire        clock,
    input  wire        reset,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    // Execution status
    output reg         idle_slot,
    output reg         skip_taken
);

    reg [7:0]            file_mem [0:FILE_DEPTH-1];
    reg [7:0]            acc_reg;
    reg                  carry_reg;
    reg                  nibble_overflow_flag_reg;
    reg                  zero_reg;
    reg [ADDR_WIDTH-1:0] file_addr_reg;
    reg [7:0]            result_reg;
    reg                  skip_pending_reg;
    reg [1:0]            period_count_reg;

    wire                 req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire                 wr_lane0 = wb_we_i & wb_sel_i[0];
    wire [2:0]           op_code = wb_dat_i[`INSTR_OP_MSB:`INSTR_OP_LSB];
    wire                 dest_file = wb_dat_i[`INSTR_DEST_BIT];
    wire [2:0]           bit_sel = wb_dat_i[`INSTR_BIT_MSB:`INSTR_BIT_LSB];
    wire [7:0]           operand = wb_dat_i[`INSTR_OPND_MSB:`INSTR_OPND_LSB];
    wire [ADDR_WIDTH-1:0] f_addr = wb_dat_i[ADDR_WIDTH-1:0];
    wire [7:0]           file_val = file_mem[f_addr];
    wire [7:0]           bit_mask = 8'h01 << bit_sel;

    // Adder shared by both add forms
    reg  [7:0]           add_b;
    wire [8:0]           add_sum = {1'b0, acc_reg} + {1'b0, add_b};
    wire [4:0]           nib_sum = {1'b0, acc_reg[3:0]} + {1'b0, add_b[3:0]};

    reg [7:0]            acc_next;
    reg                  carry_next;
    reg                  nibble_next;
    reg                  zero_next;
    reg [7:0]            result_next;
    reg                  file_we;
    reg [7:0]            file_wdata;
    reg                  skip_next;
    reg                  is_instr;
    reg                  addr_ok;

    always @*
    begin
        add_b       = (op_code == `OP_ADD_IMM) ? operand : file_val;
        acc_next    = acc_reg;
        carry_next  = carry_reg;
        nibble_next = nibble_overflow_flag_reg;
        zero_next   = zero_reg;
        result_next = result_reg;
        file_we     = 1'b0;
        file_wdata  = file_val;
        skip_next   = 1'b0;
        is_instr    = req & wr_lane0 & (wb_adr_i == `OFF_INSTR);
        addr_ok     = (wb_adr_i == `OFF_INSTR) | (wb_adr_i == `OFF_ACC) | (wb_adr_i == `OFF_FLAGS) |
                      (wb_adr_i == `OFF_RESULT) | (wb_adr_i == `OFF_FILE_ADDR) |
                      (wb_adr_i == `OFF_FILE_DATA);
        if (is_instr)
        begin
            case (op_code)
                `OP_ADD_IMM, `OP_ADD_FILE:
                begin
                    result_next = add_sum[7:0];
                    carry_next  = add_sum[8];
                    nibble_next = nib_sum[4];
                    zero_next   = (add_sum[7:0] == 8'h00);
                    if (op_code == `OP_ADD_FILE && dest_file)
                    begin
                        file_we    = 1'b1;
                        file_wdata = add_sum[7:0];
                    end
                    else
                    begin
                        acc_next = add_sum[7:0];
                    end
                end
                `OP_AND_IMM:
                begin
                    result_next = acc_reg & operand;
                    acc_next    = acc_reg & operand;
                    zero_next   = ((acc_reg & operand) == 8'h00);
                end
                `OP_AND_FILE:
                begin
                    result_next = acc_reg & file_val;
                    zero_next   = ((acc_reg & file_val) == 8'h00);
                    if (dest_file)
                    begin
                        file_we    = 1'b1;
                        file_wdata = acc_reg & file_val;
                    end
                    else
                    begin
                        acc_next = acc_reg & file_val;
                    end
                end
                `OP_BIT_CLEAR:
                begin
                    file_we     = 1'b1;
                    file_wdata  = file_val & ~bit_mask;
                    result_next = file_val & ~bit_mask;
                end
                `OP_BIT_SET:
                begin
                    file_we     = 1'b1;
                    file_wdata  = file_val | bit_mask;
                    result_next = file_val | bit_mask;
                end
                `OP_TEST_SKIP:
                begin
                    skip_next = |(file_val & bit_mask);
                end
                `OP_ZERO_FILE:
                begin
                    file_we     = 1'b1;
                    file_wdata  = 8'h00;
                    result_next = 8'h00;
                    zero_next   = 1'b1;
                end
                default:
                begin
                    file_we = 1'b0;
                end
            endcase
        end
    end

    // Instructions only taken when no idle slot is pending
    wire busy = skip_pending_reg | (period_count_reg != 2'h0);

    // Idle periods left after a taken skip, cut on purpose to the counter width
    localparam [31:0]    SKIP_IDLE_FULL = `SKIP_PERIODS - 1;
    localparam [1:0]     SKIP_IDLE      = SKIP_IDLE_FULL[1:0];

    always @(posedge clock)
    begin
        if (reset)
        begin
            acc_reg                  <= `ACC_RESET;
            carry_reg                <= 1'b0;
            nibble_overflow_flag_reg <= 1'b0;
            zero_reg                 <= 1'b0;
            file_addr_reg            <= {ADDR_WIDTH{1'b0}};
            result_reg               <= 8'h00;
            skip_pending_reg         <= 1'b0;
            period_count_reg         <= 2'h0;
            wb_ack_o                 <= 1'b0;
            wb_err_o                 <= 1'b0;
            wb_dat_o                 <= 32'h0000_0000;
            idle_slot                <= 1'b0;
            skip_taken               <= 1'b0;
        end
        else
        begin
            wb_ack_o   <= 1'b0;
            wb_err_o   <= 1'b0;
            idle_slot  <= 1'b0;
            skip_taken <= 1'b0;
            // Skipped instruction replaced by one idle period
            if (period_count_reg != 2'h0)
            begin
                period_count_reg <= period_count_reg - 2'h1;
                idle_slot        <= 1'b1;
            end
            if (req && !addr_ok)
            begin
                wb_err_o <= 1'b1;
            end
            else if (req && !(is_instr && busy))
            begin
                wb_ack_o <= 1'b1;
                if (is_instr)
                begin
                    acc_reg                  <= acc_next;
                    carry_reg                <= carry_next;
                    nibble_overflow_flag_reg <= nibble_next;
                    zero_reg                 <= zero_next;
                    result_reg               <= result_next;
                    if (skip_next)
                    begin
                        skip_taken       <= 1'b1;
                        period_count_reg <= SKIP_IDLE;
                    end
                end
                else if (wr_lane0 && wb_adr_i == `OFF_ACC)
                begin
                    acc_reg <= wb_dat_i[7:0];
                end
                else if (wr_lane0 && wb_adr_i == `OFF_FLAGS)
                begin
                    carry_reg                <= wb_dat_i[`FLAG_CARRY];
                    nibble_overflow_flag_reg <= wb_dat_i[`FLAG_NIBBLE];
                    zero_reg                 <= wb_dat_i[`FLAG_ZERO];
                end
                else if (wr_lane0 && wb_adr_i == `OFF_FILE_ADDR)
                begin
                    file_addr_reg <= wb_dat_i[ADDR_WIDTH-1:0];
                end
                wb_dat_o <= 32'h0000_0000;
                if (!wb_we_i)
                begin
                    case (wb_adr_i)
                        `OFF_ACC:       wb_dat_o <= {24'h000000, acc_reg};
                        `OFF_FLAGS:     wb_dat_o <= {27'h0, busy, skip_pending_reg, zero_reg,
                                                     nibble_overflow_flag_reg, carry_reg};
                        `OFF_RESULT:    wb_dat_o <= {24'h000000, result_reg};
                        `OFF_FILE_ADDR: wb_dat_o <= {{(32-ADDR_WIDTH){1'b0}}, file_addr_reg};
                        `OFF_FILE_DATA: wb_dat_o <= {24'h000000, file_mem[file_addr_reg]};
                        default:        wb_dat_o <= 32'h0000_0000;
                    endcase
                end
            end
            skip_pending_reg <= 1'b0;
        end
    end

    // File array: instruction writes and direct software writes
    always @(posedge clock)
    begin
        if (!reset && req && addr_ok && !(is_instr && busy))
        begin
            if (file_we)
            begin
                file_mem[f_addr] <= file_wdata;
            end
            else if (wr_lane0 && wb_adr_i == `OFF_FILE_DATA)
            begin
                file_mem[file_addr_reg] <= wb_dat_i[7:0];
            end
        end
    end

endmodule // byte_bit_op_executor

// ==== bench/byte_bit_op_props.sv ====
// Purpose: Bus answer and skip timing checks
// Assumes: Bound to the executor top ports
// Notes:   One clock domain, reset disables all
`timescale 1ns/1ps
`include "byte_bit_op_regs.vh"
module byte_bit_op_props
(
    // Clock and reset
    input wire        clock,
    input wire        reset,
    // Bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    // Status
    input wire        idle_slot,
    input wire        skip_taken
);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire bad = (wb_adr_i > 8'h14) || (wb_adr_i[1:0] != 2'h0);
    wire tst = wb_we_i && wb_adr_i == `OFF_INSTR && wb_dat_i[18:16] == `OP_TEST_SKIP;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_err_unmapped: assert property (req && bad |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    a_read_ack: assert property (req && !bad && !wb_we_i |=> wb_ack_o && !wb_err_o)
        else $error("read not answered next cycle");
    // Busy may hold an instruction one extra cycle
    a_write_ack: assert property (req && !bad && wb_we_i |-> ##[1:2] wb_ack_o)
        else $error("write not answered");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_err_single: assert property (wb_err_o |=> !wb_err_o)
        else $error("err longer than one cycle");
    a_skip_cause: assert property (skip_taken |-> wb_ack_o && $past(tst && req))
        else $error("skip without bit test write");
    a_idle_after_skip: assert property (skip_taken |=> idle_slot && !skip_taken)
        else $error("no idle period after skip");
    a_idle_cause: assert property (idle_slot |-> $past(skip_taken))
        else $error("idle period without skip");
    cover property (idle_slot);
    cover property (wb_err_o);
    cover property (req && tst);
endmodule // byte_bit_op_props

// ==== bench/tb_top.sv ====
// Purpose: Random instruction run against a bench model
// Assumes: Classic Wishbone, one instruction per write
// Notes:   Model state is seeded over the bus before each op
`timescale 1ns/1ps
`include "byte_bit_op_regs.vh"
module tb_top;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, rd;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, wb_err_o, idle_slot, skip_taken;
    logic        got_err, got_skip, got_idle, c = 1'b0, nb = 1'b0, z = 1'b0;
    logic [7:0]  acc = 8'h00, res = 8'h00, k, m, b, v, mem [0:127];
    integer      err_total = 0, cmp_count = 0, seed = 12, i;
    always #2 clock = ~clock;
    byte_bit_op_executor DUT (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .idle_slot(idle_slot), .skip_taken(skip_taken));
    task close_out;
    begin
        $display("Mismatches %0d, checks %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    // Entered just after an edge; answer sampled as seen at the edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    begin
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        @(posedge clock);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
            @(posedge clock);
        rd = wb_dat_o;
        got_err = wb_err_o;
        got_skip = skip_taken;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
        got_idle = idle_slot;
    end
    endtask
    task put(input logic [7:0] a, input logic [7:0] x);
        wb(1'b1, a, {24'h0, x}, 4'h1);
    endtask
    task get(input logic [7:0] a);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask
    task run(input logic [2:0] op, input logic d, input logic [2:0] bt, input logic [7:0] kk);
        logic [8:0] r;
        logic [7:0] o;
        logic [6:0] f;
        logic       sk, an, fl;
    begin
        f = kk[6:0];
        sk = 1'b0;
        an = op == `OP_AND_IMM || op == `OP_AND_FILE;
        fl = op == `OP_ADD_FILE || op == `OP_AND_FILE;
        o = fl ? mem[f] : kk;
        wb(1'b1, `OFF_INSTR, {13'h0, op, d, 4'h0, bt, kk}, 4'h1);
        case (op)
            `OP_BIT_CLEAR: mem[f][bt] = 1'b0;
            `OP_BIT_SET: mem[f][bt] = 1'b1;
            `OP_TEST_SKIP: sk = mem[f][bt];
            `OP_ZERO_FILE:
            begin
                mem[f] = 8'h00;
                z = 1'b1;
            end
            default:
            begin
                r = an ? {1'b0, acc & o} : acc + o;
                c = an ? c : r[8];
                nb = an ? nb : ({1'b0, acc[3:0]} + {1'b0, o[3:0]}) > 5'h0f;
                z = r[7:0] == 8'h00;
                res = r[7:0];
                if (d && fl)
                    mem[f] = r[7:0];
                else
                    acc = r[7:0];
            end
        endcase
        // Bit ops and clear report the new file value; the test leaves it
        if (op == `OP_BIT_CLEAR || op == `OP_BIT_SET || op == `OP_ZERO_FILE)
            res = mem[f];
        chk("skip", {31'h0, sk}, {31'h0, got_skip});
        chk("idle", {31'h0, sk}, {31'h0, got_idle});
        get(`OFF_ACC);
        chk("acc", {24'h0, acc}, rd);
        get(`OFF_FLAGS);
        chk("flags", {29'h0, z, nb, c}, rd);
        get(`OFF_FILE_DATA);
        chk("file", {24'h0, mem[f]}, rd);
        get(`OFF_RESULT);
        chk("result", {24'h0, res}, rd);
    end
    endtask
    initial
    begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        get(`OFF_ACC);
        chk("acc reset", 32'h0, rd);
        get(`OFF_FLAGS);
        chk("flags reset", 32'h0, rd);
        get(`OFF_INSTR);
        chk("instr read", 32'h0, rd);
        get(8'h18);
        chk("unmapped err", 32'h1, {31'h0, got_err});
        // File address keeps only its seven low bits
        put(`OFF_FILE_ADDR, 8'hff);
        get(`OFF_FILE_ADDR);
        chk("file addr", 32'h7f, rd);
        // Lane 0 off: write must be dropped
        wb(1'b1, `OFF_ACC, 32'h0000_00a5, 4'h0);
        get(`OFF_ACC);
        chk("sel ignored", 32'h0, rd);
        for (i = 0; i < 96; i = i + 1)
        begin
            k = $random(seed);
            m = $random(seed);
            b = $random(seed);
            v = (i % 16 == 0 || i % 16 == 8) ? 8'hff : $random(seed);
            k = (i % 16 == 8) ? 8'h01 : k;
            put(`OFF_FILE_ADDR, {1'b0, k[6:0]});
            put(`OFF_FILE_DATA, m);
            mem[k[6:0]] = m;
            acc = v;
            put(`OFF_ACC, acc);
            {z, nb, c} = b[6:4];
            put(`OFF_FLAGS, {5'h0, b[6:4]});
            run(i[2:0], b[3], b[2:0], k);
        end
        close_out;
    end
    initial
    begin
        #(4 * 30000);
        err_total = err_total + 1;
        close_out;
    end
endmodule // tb_top
bind byte_bit_op_executor byte_bit_op_props u_props (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .idle_slot(idle_slot), .skip_taken(skip_taken));
